/* File: hw/pwm_unit.v */
// pulse width modulator with apb register file
// assumes a single clock, apb master on clk_i and capture inputs synchronous
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "pwm_consts.vh"
module pwm_unit #(
  parameter CW = 32,
  parameter NCAP = 2
) (
  input  wire            clk_i,
  input  wire            rst_b_i,
  input  wire            ce_i,
  input  wire            psel_i,
  input  wire            penable_i,
  input  wire            pwrite_i,
  input  wire [7:0]      paddr_i,
  input  wire [31:0]     pwdata_i,
  output reg  [31:0]     prdata_o,
  output reg             pready_o,
  output reg             pslverr_o,
  input  wire [NCAP-1:0] cap_i,
  input  wire            sync_start_i,
  output reg             sync_start_o,
  output reg  [5:0]      pwm_o,
  output reg             irq_o
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  reg rst_m;
  reg rst_b;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_m <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_b <= rst_m;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [`CTRL_W-1:0] ctrl;
  reg [31:0]        prescale;
  reg [31:0]        pre_cnt;
  reg [CW-1:0]      count;
  reg [`MC_W-1:0]   matchctl;
  reg [5:0]         dbl_sel;
  reg [5:0]         out_en;
  reg [6:0]         latch_en;
  reg [6:0]         status;
  reg [6:0]         mask;
  reg [1:0]         src_mode;
  reg [3:0]         src_chan;
  reg [CW-1:0]      shadow [0:`NMATCH-1];
  reg [CW-1:0]      active [0:`NMATCH-1];
  reg [NCAP-1:0]    cap_q;
  integer           k;

  wire       wr     = psel_i & penable_i & pwrite_i & pready_o;
  wire       rd_acc = psel_i & penable_i & ~pwrite_i & ~pready_o;
  wire [7:0] mofs   = paddr_i - `OFS_MATCH0;
  wire [2:0] midx   = mofs[4:2];
  wire       is_mat = (paddr_i >= `OFS_MATCH0) && (paddr_i <= `OFS_MATCH6) &&
                      (paddr_i[1:0] == 2'h0);
  wire       mapped = is_mat || (paddr_i <= `OFS_CAPSEL && paddr_i[1:0] == 2'h0);
  wire       run    = ctrl[`CTRL_RUN] & ~ctrl[`CTRL_RESET];
  wire       pwm_on = ctrl[`CTRL_PWMEN];

  // ---------------------------------------------------------------
  // count source
  // ---------------------------------------------------------------
  wire cap_cur  = cap_i[src_chan[0 +: 1] % NCAP];
  wire cap_prev = cap_q[src_chan[0 +: 1] % NCAP];
  reg  src_tick;
  always @* begin
    case (src_mode)
      `SRC_TIMER: src_tick = 1'b1;
      `SRC_RISE:  src_tick = cap_cur & ~cap_prev;
      `SRC_FALL:  src_tick = ~cap_cur & cap_prev;
      `SRC_BOTH:  src_tick = cap_cur ^ cap_prev;
      default:    src_tick = 1'b0;
    endcase
  end
  // in counter mode the prescaler divides capture edges, not clocks
  wire pre_done = (pre_cnt >= prescale);
  wire tick     = run & src_tick & pre_done;

  // ---------------------------------------------------------------
  // match detection
  // ---------------------------------------------------------------
  wire [6:0] hit;
  genvar g;
  generate
    for (g = 0; g < `NMATCH; g = g + 1) begin : gm
      assign hit[g] = tick & (count == active[g]);
    end
  endgenerate
  reg any_rst;
  reg any_stop;
  always @* begin
    any_rst  = 1'b0;
    any_stop = 1'b0;
    for (k = 0; k < `NMATCH; k = k + 1) begin
      if (hit[k] && matchctl[3*k+`MC_RST])  any_rst  = 1'b1;
      if (hit[k] && matchctl[3*k+`MC_STOP]) any_stop = 1'b1;
    end
    // the period match always restarts the cycle in pulse mode
    if (pwm_on && hit[0]) any_rst = 1'b1;
  end

  // ---------------------------------------------------------------
  // next count
  // ---------------------------------------------------------------
  // a stop match without a reset holds the count on the matched value, so software
  // reads back the count at which the timer halted
  reg [CW-1:0] next_count;
  always @* begin
    next_count = count;
    if (ctrl[`CTRL_RESET]) begin
      next_count = {CW{1'b0}};
    end else if (tick) begin
      if (any_rst) begin
        next_count = {CW{1'b0}};
      end else if (!any_stop) begin
        next_count = count + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // ---------------------------------------------------------------
  // read data select
  // ---------------------------------------------------------------
  // picked during the access cycle so the word stands beside pready;
  // unused bits and unmapped offsets read as zero
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = `ZERO32;
    case (paddr_i)
      `OFS_CTRL:     next_rdata[`CTRL_W-1:0] = ctrl;
      `OFS_PRESCALE: next_rdata = prescale;
      `OFS_COUNT:    next_rdata[CW-1:0] = count;
      `OFS_MATCHCTL: next_rdata[`MC_W-1:0] = matchctl;
      `OFS_OUTCTL: begin
        next_rdata[`OC_DBL_HI:`OC_DBL_LO] = dbl_sel;
        next_rdata[`OC_EN_HI:`OC_EN_LO]   = out_en;
      end
      `OFS_LATCHEN:  next_rdata[`NMATCH-1:0] = latch_en;
      `OFS_STATUS:   next_rdata[`NMATCH-1:0] = status;
      `OFS_MASK:     next_rdata[`NMATCH-1:0] = mask;
      `OFS_CAPSEL: begin
        next_rdata[`SRC_MODE_HI:`SRC_MODE_LO] = src_mode;
        next_rdata[`SRC_CHAN_HI:`SRC_CHAN_LO] = src_chan;
      end
      default: begin
        if (is_mat) next_rdata[CW-1:0] = shadow[midx];
      end
    endcase
  end

  // ---------------------------------------------------------------
  // bus, counter and flags
  // ---------------------------------------------------------------
  always @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      ctrl         <= {`CTRL_W{1'b0}};
      prescale     <= `ZERO32;
      pre_cnt      <= `ZERO32;
      count        <= {CW{1'b0}};
      matchctl     <= {`MC_W{1'b0}};
      dbl_sel      <= 6'h00;
      out_en       <= 6'h00;
      latch_en     <= 7'h00;
      status       <= 7'h00;
      mask         <= 7'h00;
      src_mode     <= `SRC_TIMER;
      src_chan     <= 4'h0;
      cap_q        <= {NCAP{1'b0}};
      prdata_o     <= `ZERO32;
      pready_o     <= 1'b0;
      pslverr_o    <= 1'b0;
      irq_o        <= 1'b0;
      sync_start_o <= 1'b0;
      for (k = 0; k < `NMATCH; k = k + 1) begin
        shadow[k] <= {CW{1'b0}};
        active[k] <= {CW{1'b0}};
      end
    end else if (ce_i) begin
      cap_q     <= cap_i;
      // one wait state: setup, access, then ready
      pready_o  <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
      if (src_tick && run) begin
        pre_cnt <= pre_done ? `ZERO32 : pre_cnt + 32'h00000001;
      end
      count <= next_count;
      // the counter reset bit also clears the prescaler phase
      if (ctrl[`CTRL_RESET]) begin
        pre_cnt <= `ZERO32;
      end
      if (pwm_on && hit[0]) begin
        for (k = 0; k < `NMATCH; k = k + 1) begin
          if (latch_en[k]) active[k] <= shadow[k];
        end
      end else if (!pwm_on || !run) begin
        for (k = 0; k < `NMATCH; k = k + 1) begin
          active[k] <= shadow[k];
        end
      end
      if (any_stop) ctrl[`CTRL_RUN] <= 1'b0;
      // a slave unit starts when its master starts
      if (sync_start_i) ctrl[`CTRL_RUN] <= 1'b1;
      sync_start_o <= 1'b0;
      if (wr) begin
        case (paddr_i)
          `OFS_CTRL: begin
            ctrl         <= pwdata_i[`CTRL_W-1:0];
            sync_start_o <= pwdata_i[`CTRL_RUN] & ~ctrl[`CTRL_RUN];
          end
          `OFS_PRESCALE: prescale <= pwdata_i;
          `OFS_COUNT:    count    <= pwdata_i[CW-1:0];
          `OFS_MATCHCTL: matchctl <= pwdata_i[`MC_W-1:0];
          `OFS_OUTCTL: begin
            dbl_sel <= pwdata_i[`OC_DBL_HI:`OC_DBL_LO];
            out_en  <= pwdata_i[`OC_EN_HI:`OC_EN_LO];
          end
          `OFS_MASK:   mask <= pwdata_i[6:0];
          `OFS_CAPSEL: begin
            src_mode <= pwdata_i[`SRC_MODE_HI:`SRC_MODE_LO];
            src_chan <= pwdata_i[`SRC_CHAN_HI:`SRC_CHAN_LO];
          end
          default: ;
        endcase
        if (is_mat) shadow[midx] <= pwdata_i[CW-1:0];
      end
      // release: cleared by hardware once applied at cycle start
      if (wr && paddr_i == `OFS_LATCHEN) begin
        latch_en <= latch_en | pwdata_i[6:0];
      end else if (pwm_on && hit[0]) begin
        latch_en <= 7'h00;
      end
      for (k = 0; k < `NMATCH; k = k + 1) begin
        // a new event beats a write-one clear in the same cycle
        if (hit[k] && matchctl[3*k+`MC_INT]) begin
          status[k] <= 1'b1;
        end else if (wr && paddr_i == `OFS_STATUS && pwdata_i[k]) begin
          status[k] <= 1'b0;
        end
      end
      irq_o <= |(status & mask);
      if (rd_acc) prdata_o <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // output channels
  // ---------------------------------------------------------------
  // output n: single edge falls on match n+1; double edge (outputs 1 to 5 only) rises on n, falls on n+1
  wire [5:0] chan_q;
  wire [6:0] zero_m;
  generate
    for (g = 0; g < `NMATCH; g = g + 1) begin : gz
      assign zero_m[g] = (active[g] == {CW{1'b0}});
    end
    for (g = 0; g < `NOUT; g = g + 1) begin : gc
      pwm_channel u_ch (
        .clk_i        (clk_i),
        .rst_b_i      (rst_b),
        .ce_i         (ce_i),
        .enable_i     (out_en[g] & pwm_on),
        .double_i     (dbl_sel[g] & (g > 0)),
        .period_hit_i (hit[0]),
        .rise_hit_i   (hit[g]),
        .fall_hit_i   (hit[g+1]),
        .const_low_i  (zero_m[g+1]),
        .pwm_o        (chan_q[g])
      );
    end
  endgenerate
  always @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      pwm_o <= 6'h00;
    end else if (ce_i) begin
      pwm_o <= chan_q;
    end
  end
endmodule

/* File: hw/pwm_consts.vh */
// constants for the match based pulse width modulator
// assumes plain verilog-2005 includers
`ifndef PWM_CONSTS_VH
`define PWM_CONSTS_VH
// register byte offsets
`define OFS_CTRL      8'h00
`define OFS_PRESCALE  8'h04
`define OFS_COUNT     8'h08
`define OFS_MATCHCTL  8'h0C
`define OFS_OUTCTL    8'h10
`define OFS_LATCHEN   8'h14
`define OFS_STATUS    8'h18
`define OFS_MASK      8'h1C
`define OFS_CAPSEL    8'h20
`define OFS_MATCH0    8'h40
`define OFS_MATCH6    8'h58
// control bits
`define CTRL_RUN      0
`define CTRL_RESET    1
`define CTRL_PWMEN    3
`define CTRL_W        4
// match control: 3 bits per match, interrupt, reset, stop
`define MC_INT        0
`define MC_RST        1
`define MC_STOP       2
`define MC_W          21
// count source select
`define SRC_TIMER     2'h0
`define SRC_RISE      2'h1
`define SRC_FALL      2'h2
`define SRC_BOTH      2'h3
// output control and count source fields
`define OC_DBL_LO     0
`define OC_DBL_HI     5
`define OC_EN_LO      8
`define OC_EN_HI      13
`define SRC_MODE_LO   0
`define SRC_MODE_HI   1
`define SRC_CHAN_LO   4
`define SRC_CHAN_HI   7
`define NMATCH        7
`define NOUT          6
`define ZERO32        32'h00000000
`endif

/* File: hw/pwm_channel.v */
// one pulse output channel: single or double edge
// assumes match strobes are one-cycle pulses from the shared counter
`timescale 1ns/1ps
module pwm_channel (
  input  wire clk_i,
  input  wire rst_b_i,
  input  wire ce_i,
  input  wire enable_i,
  input  wire double_i,
  input  wire period_hit_i,
  input  wire rise_hit_i,
  input  wire fall_hit_i,
  input  wire const_low_i,
  output reg  pwm_o
);
  reg next_pwm;
  always @* begin
    next_pwm = pwm_o;
    if (!enable_i) begin
      next_pwm = 1'b0;
    end else if (double_i) begin
      // fall wins over rise when both land on the same count
      if (rise_hit_i) next_pwm = 1'b1;
      if (fall_hit_i) next_pwm = 1'b0;
    end else begin
      if (period_hit_i && !const_low_i) next_pwm = 1'b1;
      if (fall_hit_i) next_pwm = 1'b0;
    end
  end
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwm_o <= 1'b0;
    end else if (ce_i) begin
      pwm_o <= next_pwm;
    end
  end
endmodule

/* File: tb/pwm_unit_properties.sv */
// port checker for pwm_unit: bus handshake, pulses, clock-enable freeze
// assumes one clock domain and an active low reset on rst_b_i
`timescale 1ns/1ps
module pwm_unit_chk #(
  parameter CW   = 32,
  parameter NCAP = 2
) (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        ce_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        sync_start_o,
  input wire logic [5:0]  pwm_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  ready_answer_a: assert property (psel_i && penable_i && !pready_o |-> ##[1:2] pready_o)
    else $error("no ready after access");
  ready_access_a: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  err_data_a: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
    else $error("refused read not zero");
  sync_pulse_a: assert property (sync_start_o |=> !sync_start_o)
    else $error("sync pulse too long");
  pwm_freeze_a: assert property (!ce_i |=> $stable(pwm_o))
    else $error("outputs moved while frozen");
  irq_freeze_a: assert property (!ce_i |=> $stable(irq_o))
    else $error("irq moved while frozen");
  cover property ($rose(pwm_o[3]));
  cover property (pslverr_o);
  cover property ($rose(irq_o));
endmodule
bind pwm_unit pwm_unit_chk #(.CW(CW), .NCAP(NCAP)) u_chk (.clk_i, .rst_b_i, .ce_i, .psel_i,
  .penable_i, .pwrite_i, .prdata_o, .pready_o, .pslverr_o, .sync_start_o, .pwm_o, .irq_o);

/* File: tb/pwm_load.sv */
// load model: counts high cycles on each pulse output, like a duty meter
// assumes clr_i is driven at the clock edge by the bench
`timescale 1ns/1ps
module pwm_load (
  input  wire logic             clk_i,
  input  wire logic             clr_i,
  input  wire logic [5:0]       pwm_i,
  output logic      [5:0][15:0] hi_o
);
  always @(posedge clk_i)
    for (int k = 0; k < 6; k++)
      hi_o[k] <= clr_i ? 16'h0000 : hi_o[k] + {15'h0000, pwm_i[k] === 1'b1};
endmodule

/* File: tb/tb.sv */
// bench for pwm_unit: apb master tasks, load model, one task per scenario
// assumes the register map of pwm_consts.vh and one wait state per transfer
`timescale 1ns/1ps
`include "pwm_consts.vh"
module tb;
  logic        clk_i = 0, rst_b_i = 0, ce_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic        sync_i = 0, clr = 0, seen = 0, err;
  logic [7:0]  paddr_i = 0;
  logic [31:0] pwdata_i = 0, rd, c;
  logic [1:0]  cap_i = 0;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, sync_start_o, irq_o;
  wire  [5:0]  pwm_o;
  int          n_fail = 0, tests_run = 0;
  logic [5:0][15:0] hi;
  pwm_unit DUT (.clk_i, .rst_b_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .cap_i, .sync_start_i(sync_i), .sync_start_o, .pwm_o,
    .irq_o);
  pwm_load u_load (.clk_i, .clr_i(clr), .pwm_i(pwm_o), .hi_o(hi));
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (sync_start_o === 1'b1) seen <= 1;
  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  // the idle edge after each transfer keeps a strobe from being set twice at once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel_i <= 1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clk_i) penable_i <= 1;
    do begin
      @(posedge clk_i);
      t++;
    end while (pready_o !== 1'b1 && t < 50);
    if (pready_o !== 1'b1) begin
      n_fail++;
      $display("BAD %0t no ready from slave", $time);
    end
    rd = prdata_o; err = pslverr_o;
    psel_i <= 0; penable_i <= 0;
    @(posedge clk_i);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); apb(1, a, d); endtask
  task rdr(input logic [7:0] a); apb(0, a, 32'h0); endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task meas;
    repeat (30) @(posedge clk_i);
    clr <= 1;
    @(posedge clk_i) clr <= 0;
    repeat (100) @(posedge clk_i);
    @(posedge clk_i);
  endtask
  task settle; repeat (2) @(posedge clk_i); endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_bus;
    wr(`OFS_PRESCALE, 32'hFFFFFFFF);
    rdr(`OFS_PRESCALE); chk(rd, 32'hFFFFFFFF);
    rdr(8'h30); chk(err, 1'b1); chk(rd, 32'h0);
    $display("test bus done");
  endtask
  task t_pwm;
    logic [31:0] mv [7] = '{32'h9, 32'h3, 32'h0, 32'h2, 32'h7, 32'h8, 32'h1};
    wr(`OFS_PRESCALE, 32'h0);
    for (int k = 0; k < 7; k++) wr(`OFS_MATCH0 + 8'(4 * k), mv[k]);
    wr(`OFS_OUTCTL, 32'h00002B28);
    wr(`OFS_CTRL, 32'h2); wr(`OFS_CTRL, 32'h9); wr(`OFS_LATCHEN, 32'h7F);
    meas;
    chk(hi[0], 40);
    chk(hi[1], 0);
    chk(hi[2] + hi[4], 0);
    chk(hi[3], 50);
    chk(hi[5], 30);
    wr(8'h44, 32'h6); meas; chk(hi[0], 40);
    wr(`OFS_LATCHEN, 32'h2); meas; chk(hi[0], 70);
    ce_i <= 0; repeat (6) @(posedge clk_i); ce_i <= 1;
    wr(`OFS_CTRL, 32'h2);
    $display("test pwm done");
  endtask
  task t_irq;
    seen <= 0;
    wr(`OFS_MASK, 32'h0); wr(`OFS_MATCHCTL, 32'h5); wr(`OFS_STATUS, 32'h7F);
    wr(`OFS_CTRL, 32'h1);
    repeat (30) @(posedge clk_i);
    repeat (2) begin rdr(`OFS_COUNT); chk(rd, 32'h9); end
    rdr(`OFS_STATUS); chk(rd & 32'h1, 32'h1);
    chk(irq_o, 1'b0);
    wr(`OFS_MASK, 32'h1); settle; chk(irq_o, 1'b1);
    wr(`OFS_CTRL, 32'h2); wr(`OFS_STATUS, 32'h1); settle; chk(irq_o, 1'b0);
    chk(seen, 1'b1);
    $display("test irq done");
  endtask
  task t_cap;
    wr(`OFS_MATCHCTL, 32'h0); wr(`OFS_PRESCALE, 32'h1);
    for (int m = 1; m < 4; m++) begin
      wr(`OFS_CTRL, 32'h2); wr(`OFS_CAPSEL, 32'(m)); wr(`OFS_CTRL, 32'h1);
      repeat (10) begin
        cap_i <= 2'h1; repeat (3) @(posedge clk_i);
        cap_i <= 2'h0; repeat (3) @(posedge clk_i);
      end
      rdr(`OFS_COUNT); chk(rd, m == 3 ? 32'hA : 32'h5);
    end
    $display("test cap done");
  endtask
  task t_sync;
    wr(`OFS_CTRL, 32'h2); wr(`OFS_CTRL, 32'h0);
    sync_i <= 1;
    @(posedge clk_i) sync_i <= 0;
    rdr(`OFS_CTRL); chk(rd & 32'h1, 32'h1);
    $display("test sync done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1;
    repeat (4) @(posedge clk_i);
    t_bus; t_pwm; t_irq; t_cap; t_sync;
    complete_run;
  end
endmodule
